// [shared/ddscr_defs.svh]
// register addresses, field positions and reset values of the channel control register set
`ifndef DDSCR_DEFS_SVH
`define DDSCR_DEFS_SVH

// ==========================================================================
// register addresses (shared by all channels)
`define DDSCR_ADDR_CHSEL    8'h00
`define DDSCR_ADDR_GFUNC2   8'h02
`define DDSCR_ADDR_CHFUNC   8'h03
`define DDSCR_ADDR_FTW      8'h04
`define DDSCR_ADDR_POW      8'h05
`define DDSCR_ADDR_AMPCTL   8'h06
`define DDSCR_ADDR_SWRATE   8'h07
`define DDSCR_ADDR_RDW      8'h08
`define DDSCR_ADDR_FDW      8'h09

// ==========================================================================
// channel_function fields
`define DDSCR_CF_SINE       0
`define DDSCR_CF_PCLR       1
`define DDSCR_CF_PACLR      2
`define DDSCR_CF_SCLR       3
`define DDSCR_CF_SACLR      4
`define DDSCR_CF_MATCH      5
`define DDSCR_CF_DACPD      6
`define DDSCR_CF_DIGPD      7
`define DDSCR_CF_LSB_LO     8
`define DDSCR_CF_MBZ        10
`define DDSCR_CF_SRLOAD     13
`define DDSCR_CF_SWEEP      14
`define DDSCR_CF_NODWELL    15
`define DDSCR_CF_MOD_LO     22

// ==========================================================================
// amplitude_control fields
`define DDSCR_AC_SCALE_LO   0
`define DDSCR_AC_RRLOAD     10
`define DDSCR_AC_AUTO       11
`define DDSCR_AC_MULT       12
`define DDSCR_AC_STEP_LO    14
`define DDSCR_AC_RATE_LO    16

// ==========================================================================
// global function two fields
`define DDSCR_G2_PCLR       12
`define DDSCR_G2_PACLR      13
`define DDSCR_G2_SCLR       14
`define DDSCR_G2_SACLR      15

// ==========================================================================
// reset values
`define DDSCR_RST_CHSEL     8'hF0
`define DDSCR_RST_CHFUNC    24'h00_0000
`define DDSCR_RST_AMPCTL    24'h00_0000
`define DDSCR_RST_WORD      32'h0000_0000
`define DDSCR_NCH           4

`endif

// [shared/ddscr_pkg.sv]
// types of the channel control register set
`default_nettype none
package ddscr_pkg;

   // active per-channel control fields
   typedef struct packed {
      logic        sine_sel;
      logic        phase_clr;
      logic        phase_autoclr_pulse;
      logic        sweep_clr;
      logic        sweep_autoclr_pulse;
      logic        match_delay;
      logic        dac_pd;
      logic        dig_pd;
      logic [1:0]  dac_lsb;
      logic        sweep_rate_reload;
      logic        sweep_en;
      logic        no_dwell;
      logic [1:0]  mod_sel;
      logic [13:0] phase_offset;
      logic [31:0] ftw;
      logic [9:0]  amp_scale;
      logic        amp_rate_reload;
      logic        amp_mult_en;
      logic        amp_auto;
      logic        amp_bypass;
      logic [1:0]  amp_step;
      logic [7:0]  amp_rate;
      logic [15:0] sweep_rate;
      logic [31:0] rise_delta;
      logic [31:0] fall_delta;
   } ddscr_chan_s;

   // register write request from the serial port
   typedef struct packed {
      logic        wr;
      logic [7:0]  addr;
      logic [31:0] data;
   } ddscr_wr_s;

endpackage : ddscr_pkg
`default_nettype wire

// [src/ddscr_regs.sv]
// per-channel control register set with buffered update
`timescale 1ns/1ps
`default_nettype none
`include "ddscr_defs.svh"
// Behaviour
// - global sweep autoclear zeros all sweep accumulators
// - function bit0 picks sine, else cosine
// - function bit1 holds phase accumulator cleared
// - function bit2 zeros phase accumulator on update
// - function bit3 holds sweep accumulator cleared
// - function bit4 zeros sweep accumulator on update
// - function bit5 enables matched pipeline delay
// - function bit6 powers down channel DAC
// - function bit7 powers down channel digital core
// - DAC step field defaults to 00
// - function bit13 reloads sweep timer on update
// - function bit14 enables linear sweep
// - no-dwell ignored while sweep disabled
// - top two bits select modulation type
// - phase offset is fourteen bits, top unused
// - amplitude scale factor in bits 9..0
// - amplitude bit10 reloads timer on update/profile
// - bit11 picks auto ramp when multiplier on
// - bit12 zero bypasses and stops multiplier
// - amplitude step bits 15..14, rate 23..16
// - sweep rate sixteen bits, delta words 32
// - writes reach only channel-enabled channels
module ddscr_regs
(
   // clock and reset
   input  wire logic                  core_clk,
   input  wire logic                  sys_rst,
   // register write port from the serial interface
   input  wire ddscr_pkg::ddscr_wr_s  wr_req,
   // update strobe and profile select inputs
   input  wire logic                  io_update,
   input  wire logic [3:0]            profile_select_inputs,
   // register read port
   input  wire logic [7:0]            rd_addr,
   input  wire logic [1:0]            rd_chan,
   output logic      [31:0]           rd_data,
   // active controls per channel
   output ddscr_pkg::ddscr_chan_s     chan_ctl [`DDSCR_NCH],
   output logic      [3:0]            amp_timer_reload,
   output logic      [3:0]            sweep_timer_reload
);

   // ======================================================================
   // global registers
   logic [7:0]  channel_select_r;
   logic [15:0] global_function_two_buf_r;
   logic [15:0] global_function_two_r;
   logic [3:0]  profile_select_inputs_r;
   logic        profile_change;

   // the channel enable nibble acts immediately, without an update
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
         channel_select_r <= `DDSCR_RST_CHSEL;
      else if (wr_req.wr && wr_req.addr == `DDSCR_ADDR_CHSEL)
         channel_select_r <= wr_req.data[7:0];
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         global_function_two_buf_r <= 16'h0000;
         global_function_two_r     <= 16'h0000;
      end
      else
      begin
         if (wr_req.wr && wr_req.addr == `DDSCR_ADDR_GFUNC2)
            global_function_two_buf_r <= wr_req.data[15:0];
         if (io_update)
            global_function_two_r <= global_function_two_buf_r;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
         profile_select_inputs_r <= 4'h0;
      else
         profile_select_inputs_r <= profile_select_inputs;
   end

   assign profile_change = profile_select_inputs_r != profile_select_inputs;

   // ======================================================================
   // per-channel buffer and active registers
   genvar ch;
   generate
      for (ch = 0; ch < `DDSCR_NCH; ch++)
      begin : g_chan
         logic [23:0] channel_function_buf_r, channel_function_r;
         logic [15:0] phase_offset_word_buf_r, phase_offset_word_r;
         logic [31:0] frequency_tuning_word_buf_r, frequency_tuning_word_r;
         logic [23:0] amplitude_control_buf_r, amplitude_control_r;
         logic [15:0] sweep_ramp_rate_buf_r, sweep_ramp_rate_r;
         logic [31:0] rising_delta_word_buf_r, rising_delta_word_r;
         logic [31:0] falling_delta_word_buf_r, falling_delta_word_r;
         logic        chan_wr;
         logic        phase_az_r;
         logic        sweep_az_r;

         assign chan_wr = wr_req.wr && channel_select_r[4 + ch];

         // buffered writes
         always_ff @(posedge core_clk)
         begin
            if (sys_rst)
            begin
               channel_function_buf_r      <= `DDSCR_RST_CHFUNC;
               phase_offset_word_buf_r     <= 16'h0000;
               frequency_tuning_word_buf_r <= `DDSCR_RST_WORD;
               amplitude_control_buf_r     <= `DDSCR_RST_AMPCTL;
               sweep_ramp_rate_buf_r       <= 16'h0000;
               rising_delta_word_buf_r     <= `DDSCR_RST_WORD;
               falling_delta_word_buf_r    <= `DDSCR_RST_WORD;
            end
            else if (chan_wr)
            begin
               unique case (wr_req.addr)
                  `DDSCR_ADDR_CHFUNC: channel_function_buf_r      <= wr_req.data[23:0];
                  `DDSCR_ADDR_POW:    phase_offset_word_buf_r     <= wr_req.data[15:0];
                  `DDSCR_ADDR_FTW:    frequency_tuning_word_buf_r <= wr_req.data;
                  `DDSCR_ADDR_AMPCTL: amplitude_control_buf_r     <= wr_req.data[23:0];
                  `DDSCR_ADDR_SWRATE: sweep_ramp_rate_buf_r       <= wr_req.data[15:0];
                  `DDSCR_ADDR_RDW:    rising_delta_word_buf_r     <= wr_req.data;
                  `DDSCR_ADDR_FDW:    falling_delta_word_buf_r    <= wr_req.data;
                  default: ;
               endcase
            end
         end

         // transfer to active registers on the update strobe
         always_ff @(posedge core_clk)
         begin
            if (sys_rst)
            begin
               channel_function_r      <= `DDSCR_RST_CHFUNC;
               phase_offset_word_r     <= 16'h0000;
               frequency_tuning_word_r <= `DDSCR_RST_WORD;
               amplitude_control_r     <= `DDSCR_RST_AMPCTL;
               sweep_ramp_rate_r       <= 16'h0000;
               rising_delta_word_r     <= `DDSCR_RST_WORD;
               falling_delta_word_r    <= `DDSCR_RST_WORD;
            end
            else if (io_update)
            begin
               channel_function_r      <= channel_function_buf_r;
               phase_offset_word_r     <= phase_offset_word_buf_r;
               frequency_tuning_word_r <= frequency_tuning_word_buf_r;
               amplitude_control_r     <= amplitude_control_buf_r;
               sweep_ramp_rate_r       <= sweep_ramp_rate_buf_r;
               rising_delta_word_r     <= rising_delta_word_buf_r;
               falling_delta_word_r    <= falling_delta_word_buf_r;
            end
         end

         // one-cycle autoclear pulses follow the update, using the new settings
         always_ff @(posedge core_clk)
         begin
            if (sys_rst)
            begin
               phase_az_r <= 1'b0;
               sweep_az_r <= 1'b0;
            end
            else
            begin
               phase_az_r <= io_update &&
                  (channel_function_buf_r[`DDSCR_CF_PACLR] ||
                   global_function_two_buf_r[`DDSCR_G2_PACLR]);
               sweep_az_r <= io_update &&
                  (channel_function_buf_r[`DDSCR_CF_SACLR] ||
                   global_function_two_buf_r[`DDSCR_G2_SACLR]);
            end
         end

         // timer reloads: sweep on the update strobe, amplitude on the update strobe or a profile change, when the load bits are set
         always_ff @(posedge core_clk)
         begin
            if (sys_rst)
            begin
               sweep_timer_reload[ch] <= 1'b0;
               amp_timer_reload[ch]   <= 1'b0;
            end
            else
            begin
               sweep_timer_reload[ch] <= io_update &&
                  channel_function_buf_r[`DDSCR_CF_SRLOAD];
               amp_timer_reload[ch]   <= (io_update || profile_change) &&
                  amplitude_control_buf_r[`DDSCR_AC_RRLOAD];
            end
         end

         // active controls; channel clear bits act straight from the written value, global clear bits only after the update
         always_comb
         begin
            chan_ctl[ch].sine_sel            = channel_function_r[`DDSCR_CF_SINE];
            chan_ctl[ch].phase_clr           = channel_function_buf_r[`DDSCR_CF_PCLR] ||
               channel_function_r[`DDSCR_CF_PCLR] ||
               global_function_two_r[`DDSCR_G2_PCLR];
            chan_ctl[ch].phase_autoclr_pulse = phase_az_r;
            chan_ctl[ch].sweep_clr           = channel_function_buf_r[`DDSCR_CF_SCLR] ||
               channel_function_r[`DDSCR_CF_SCLR] ||
               global_function_two_r[`DDSCR_G2_SCLR];
            chan_ctl[ch].sweep_autoclr_pulse = sweep_az_r;
            chan_ctl[ch].match_delay         = channel_function_r[`DDSCR_CF_MATCH];
            chan_ctl[ch].dac_pd              = channel_function_r[`DDSCR_CF_DACPD];
            chan_ctl[ch].dig_pd              = channel_function_r[`DDSCR_CF_DIGPD];
            chan_ctl[ch].dac_lsb             =
               channel_function_r[`DDSCR_CF_LSB_LO +: 2];
            chan_ctl[ch].sweep_rate_reload   = channel_function_r[`DDSCR_CF_SRLOAD];
            chan_ctl[ch].sweep_en            = channel_function_r[`DDSCR_CF_SWEEP];
            chan_ctl[ch].no_dwell            = channel_function_r[`DDSCR_CF_NODWELL] &&
               channel_function_r[`DDSCR_CF_SWEEP];
            chan_ctl[ch].mod_sel             =
               channel_function_r[`DDSCR_CF_MOD_LO +: 2];
            chan_ctl[ch].phase_offset        = phase_offset_word_r[13:0];
            chan_ctl[ch].ftw                 = frequency_tuning_word_r;
            chan_ctl[ch].amp_scale           =
               amplitude_control_r[`DDSCR_AC_SCALE_LO +: 10];
            chan_ctl[ch].amp_rate_reload     = amplitude_control_r[`DDSCR_AC_RRLOAD];
            chan_ctl[ch].amp_mult_en         = amplitude_control_r[`DDSCR_AC_MULT];
            chan_ctl[ch].amp_bypass          = !amplitude_control_r[`DDSCR_AC_MULT];
            chan_ctl[ch].amp_auto            = amplitude_control_r[`DDSCR_AC_AUTO] &&
               amplitude_control_r[`DDSCR_AC_MULT];
            chan_ctl[ch].amp_step            =
               amplitude_control_r[`DDSCR_AC_STEP_LO +: 2];
            chan_ctl[ch].amp_rate            =
               amplitude_control_r[`DDSCR_AC_RATE_LO +: 8];
            chan_ctl[ch].sweep_rate          = sweep_ramp_rate_r;
            chan_ctl[ch].rise_delta          = rising_delta_word_r;
            chan_ctl[ch].fall_delta          = falling_delta_word_r;
         end
      end
   endgenerate

   // ======================================================================
   // readback of the buffered (last written) values; phase offset bits 15..14 read as zero
   // bit 10 of channel_function is stored as written; software keeps it zero
   logic [31:0] rd_nxt;

   always_comb
   begin
      rd_nxt = 32'h0000_0000;
      unique case (rd_chan)
         2'd0: rd_nxt = chan_rd(g_chan[0].channel_function_buf_r,
                                g_chan[0].phase_offset_word_buf_r,
                                g_chan[0].frequency_tuning_word_buf_r,
                                g_chan[0].amplitude_control_buf_r,
                                g_chan[0].sweep_ramp_rate_buf_r,
                                g_chan[0].rising_delta_word_buf_r,
                                g_chan[0].falling_delta_word_buf_r, rd_addr);
         2'd1: rd_nxt = chan_rd(g_chan[1].channel_function_buf_r,
                                g_chan[1].phase_offset_word_buf_r,
                                g_chan[1].frequency_tuning_word_buf_r,
                                g_chan[1].amplitude_control_buf_r,
                                g_chan[1].sweep_ramp_rate_buf_r,
                                g_chan[1].rising_delta_word_buf_r,
                                g_chan[1].falling_delta_word_buf_r, rd_addr);
         2'd2: rd_nxt = chan_rd(g_chan[2].channel_function_buf_r,
                                g_chan[2].phase_offset_word_buf_r,
                                g_chan[2].frequency_tuning_word_buf_r,
                                g_chan[2].amplitude_control_buf_r,
                                g_chan[2].sweep_ramp_rate_buf_r,
                                g_chan[2].rising_delta_word_buf_r,
                                g_chan[2].falling_delta_word_buf_r, rd_addr);
         2'd3: rd_nxt = chan_rd(g_chan[3].channel_function_buf_r,
                                g_chan[3].phase_offset_word_buf_r,
                                g_chan[3].frequency_tuning_word_buf_r,
                                g_chan[3].amplitude_control_buf_r,
                                g_chan[3].sweep_ramp_rate_buf_r,
                                g_chan[3].rising_delta_word_buf_r,
                                g_chan[3].falling_delta_word_buf_r, rd_addr);
      endcase
      if (rd_addr == `DDSCR_ADDR_CHSEL)
         rd_nxt = {24'h00_0000, channel_select_r};
      else if (rd_addr == `DDSCR_ADDR_GFUNC2)
         rd_nxt = {16'h0000, global_function_two_buf_r};
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
         rd_data <= 32'h0000_0000;
      else
         rd_data <= rd_nxt;
   end

   function automatic logic [31:0] chan_rd(
      input logic [23:0] cf,
      input logic [15:0] pow,
      input logic [31:0] ftw,
      input logic [23:0] ac,
      input logic [15:0] sr,
      input logic [31:0] rising_delta_word,
      input logic [31:0] falling_delta_word,
      input logic [7:0]  a);
      chan_rd = 32'h0000_0000;
      unique case (a)
         `DDSCR_ADDR_CHFUNC: chan_rd = {8'h00, cf};
         `DDSCR_ADDR_POW:    chan_rd = {16'h0000, 2'b00, pow[13:0]};
         `DDSCR_ADDR_FTW:    chan_rd = ftw;
         `DDSCR_ADDR_AMPCTL: chan_rd = {8'h00, ac};
         `DDSCR_ADDR_SWRATE: chan_rd = {16'h0000, sr};
         `DDSCR_ADDR_RDW:    chan_rd = rising_delta_word;
         `DDSCR_ADDR_FDW:    chan_rd = falling_delta_word;
         default:            chan_rd = 32'h0000_0000;
      endcase
   endfunction : chan_rd

endmodule : ddscr_regs
`default_nettype wire

// [sim/ddscr_regs_chk.sv]
// assertion checker for the channel control register set
`timescale 1ns/1ps
`default_nettype none
`include "ddscr_defs.svh"
module ddscr_regs_chk
(
   // clock and reset
   input wire logic                   core_clk,
   input wire logic                   sys_rst,
   // requests
   input wire ddscr_pkg::ddscr_wr_s   wr_req,
   input wire logic                   io_update,
   input wire logic [3:0]             profile_select_inputs,
   input wire logic [7:0]             rd_addr,
   input wire logic [1:0]             rd_chan,
   // answers
   input wire logic [31:0]            rd_data,
   input wire ddscr_pkg::ddscr_chan_s chan_ctl [`DDSCR_NCH],
   input wire logic [3:0]             amp_timer_reload,
   input wire logic [3:0]             sweep_timer_reload
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   // ==========================================================================
   // update steps
   sequence s_update;
      io_update;
   endsequence
   // no cause for a fresh reload at this edge
   sequence s_quiet;
      !io_update && $stable(profile_select_inputs);
   endsequence

   // ==========================================================================
   // per-channel relations
   for (genvar c = 0; c < `DDSCR_NCH; c++)
   begin : g_ch
      a_sweep_reload:
      assert property (s_update ##1 chan_ctl[c].sweep_rate_reload |-> sweep_timer_reload[c])
         else $error("sweep timer reload missed");
      a_sweep_cause:
      assert property (sweep_timer_reload[c] |-> $past(io_update) && chan_ctl[c].sweep_rate_reload)
         else $error("sweep timer reload without cause");
      a_amp_reload:
      assert property (s_update ##1 chan_ctl[c].amp_rate_reload |-> amp_timer_reload[c])
         else $error("amplitude timer reload missed");
      a_amp_cause:
      assert property (amp_timer_reload[c] && !$past(io_update)
         |-> $past(profile_select_inputs) != $past(profile_select_inputs, 2))
         else $error("amplitude timer reload without cause");
      a_amp_width:
      assert property (amp_timer_reload[c] ##0 s_quiet |=> !amp_timer_reload[c])
         else $error("amplitude reload pulse too long");
      a_autoclr_cause:
      assert property (chan_ctl[c].sweep_autoclr_pulse || chan_ctl[c].phase_autoclr_pulse
         |-> $past(io_update))
         else $error("autoclear pulse without update");
      a_nodwell_gate:
      assert property (chan_ctl[c].no_dwell |-> chan_ctl[c].sweep_en)
         else $error("no-dwell active without sweep");
      a_auto_gate:
      assert property (chan_ctl[c].amp_auto |-> chan_ctl[c].amp_mult_en)
         else $error("auto ramp active without multiplier");
      a_bypass_mult:
      assert property (chan_ctl[c].amp_bypass != chan_ctl[c].amp_mult_en)
         else $error("bypass does not oppose multiplier");
      a_active_hold:
      assert property (!$past(io_update) && !$past(sys_rst)
         |-> $stable(chan_ctl[c].ftw) && $stable(chan_ctl[c].mod_sel))
         else $error("active value moved without update");
   end
endmodule : ddscr_regs_chk

bind ddscr_regs ddscr_regs_chk chk_u
(
   .core_clk(core_clk), .sys_rst(sys_rst), .wr_req(wr_req), .io_update(io_update),
   .profile_select_inputs(profile_select_inputs), .rd_addr(rd_addr), .rd_chan(rd_chan),
   .rd_data(rd_data), .chan_ctl(chan_ctl), .amp_timer_reload(amp_timer_reload),
   .sweep_timer_reload(sweep_timer_reload)
);
`default_nettype wire

// [sim/ddscr_regs_tb.sv]
// self-checking bench for the channel control register set
`timescale 1ns/1ps
`default_nettype none
`include "ddscr_defs.svh"
module ddscr_regs_tb;
   logic                   core_clk              = 1'b0;
   logic                   sys_rst               = 1'b1;
   ddscr_pkg::ddscr_wr_s   wr_req                = '0;
   logic                   io_update             = 1'b0;
   logic [3:0]             profile_select_inputs = 4'h0;
   logic [7:0]             rd_addr               = 8'h00;
   logic [1:0]             rd_chan               = 2'h0;
   logic [31:0]            rd_data;
   ddscr_pkg::ddscr_chan_s chan_ctl [`DDSCR_NCH];
   logic [3:0]             amp_timer_reload;
   logic [3:0]             sweep_timer_reload;
   int                     fails                 = 0;
   int                     compares              = 0;

   always #12.5 core_clk = ~core_clk;

   ddscr_regs dut_u
   (
      .core_clk(core_clk), .sys_rst(sys_rst), .wr_req(wr_req), .io_update(io_update),
      .profile_select_inputs(profile_select_inputs), .rd_addr(rd_addr), .rd_chan(rd_chan),
      .rd_data(rd_data), .chan_ctl(chan_ctl), .amp_timer_reload(amp_timer_reload),
      .sweep_timer_reload(sweep_timer_reload)
   );

   // ==========================================================================
   // bus and compare helpers
   task automatic step();
      @(posedge core_clk);
      #2;
   endtask : step

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : check

   // one idle cycle after each word keeps the strobe from being re-driven in one step
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      wr_req = '{wr: 1'b1, addr: a, data: d};
      step();
      wr_req.wr = 1'b0;
      step();
   endtask : wr

   task automatic upd();
      io_update = 1'b1;
      step();
      io_update = 1'b0;
   endtask : upd

   task automatic rd(input logic [7:0] a, input logic [1:0] ch, input logic [31:0] exp);
      rd_addr = a;
      rd_chan = ch;
      step();
      check(rd_data, exp);
   endtask : rd

   task automatic stop_test();
      $display("mismatches %0d comparisons %0d", fails, compares);
      if (fails == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : stop_test

   // ==========================================================================
   // scenarios
   task automatic t_reset();
      rd(`DDSCR_ADDR_CHSEL, 2'h0, 32'h0000_00F0);
      rd(`DDSCR_ADDR_CHFUNC, 2'h0, 32'h0000_0000);
      check(32'({chan_ctl[0].dac_lsb, chan_ctl[0].sine_sel}), 32'h0000_0000);
      check(32'(chan_ctl[0].amp_bypass), 32'h0000_0001);
   endtask : t_reset

   task automatic t_buffer();
      wr(`DDSCR_ADDR_FTW, 32'h1234_5678);
      rd(`DDSCR_ADDR_FTW, 2'h3, 32'h1234_5678);
      check(chan_ctl[3].ftw, 32'h0000_0000);
      wr(`DDSCR_ADDR_CHSEL, 32'h0000_0020);
      wr(`DDSCR_ADDR_FTW, 32'hAAAA_5555);
      wr(`DDSCR_ADDR_CHSEL, 32'h0000_00F0);
      wr(`DDSCR_ADDR_POW, 32'h0000_FFFF);
      wr(`DDSCR_ADDR_SWRATE, 32'h0001_BEEF);
      wr(`DDSCR_ADDR_RDW, 32'h89AB_CDEF);
      wr(`DDSCR_ADDR_FDW, 32'h0123_4567);
      upd();
      check(chan_ctl[1].ftw, 32'hAAAA_5555);
      check(chan_ctl[0].ftw, 32'h1234_5678);
      check(32'(chan_ctl[2].phase_offset), 32'h0000_3FFF);
      check(32'(chan_ctl[2].sweep_rate), 32'h0000_BEEF);
      check(chan_ctl[2].rise_delta, 32'h89AB_CDEF);
      check(chan_ctl[2].fall_delta, 32'h0123_4567);
      rd(8'h0A, 2'h0, 32'h0000_0000);
   endtask : t_buffer

   task automatic t_func();
      wr(`DDSCR_ADDR_CHFUNC, 32'h00C0_E2F5);
      upd();
      check(32'({chan_ctl[0].sine_sel, chan_ctl[0].match_delay, chan_ctl[0].dac_pd,
                 chan_ctl[0].dig_pd}), 32'h0000_000F);
      check(32'({chan_ctl[0].phase_autoclr_pulse, chan_ctl[0].sweep_autoclr_pulse}),
            32'h0000_0003);
      check(32'({chan_ctl[0].dac_lsb, chan_ctl[0].mod_sel}), 32'h0000_000B);
      check(32'({chan_ctl[0].sweep_en, chan_ctl[0].no_dwell, sweep_timer_reload}),
            32'h0000_003F);
      step();
      check(32'({chan_ctl[0].phase_autoclr_pulse, sweep_timer_reload}), 32'h0000_0000);
      wr(`DDSCR_ADDR_CHFUNC, 32'h0000_800A);
      check(32'({chan_ctl[0].phase_clr, chan_ctl[0].sweep_clr}), 32'h0000_0003);
      upd();
      check(32'({chan_ctl[0].no_dwell, chan_ctl[0].phase_autoclr_pulse,
                 chan_ctl[0].sweep_autoclr_pulse, sweep_timer_reload}),
            32'h0000_0000);
      wr(`DDSCR_ADDR_CHFUNC, 32'h0000_0000);
      // the active copy keeps the clear bits set until the update moves the zeros over
      upd();
      check(32'({chan_ctl[0].phase_clr, chan_ctl[0].sweep_clr}), 32'h0000_0000);
   endtask : t_func

   task automatic t_amp();
      wr(`DDSCR_ADDR_AMPCTL, 32'h00A5_9D55);
      upd();
      check(32'({chan_ctl[0].amp_scale, chan_ctl[0].amp_step, chan_ctl[0].amp_rate}),
            32'h0005_56A5);
      check(32'({chan_ctl[0].amp_rate_reload, chan_ctl[0].amp_auto, chan_ctl[0].amp_mult_en,
                 chan_ctl[0].amp_bypass, amp_timer_reload}), 32'h0000_00EF);
      step();
      profile_select_inputs = 4'h5;
      step();
      check(32'(amp_timer_reload), 32'h0000_000F);
      wr(`DDSCR_ADDR_AMPCTL, 32'h0000_0800);
      upd();
      check(32'({chan_ctl[0].amp_auto, chan_ctl[0].amp_bypass, amp_timer_reload}),
            32'h0000_0010);
      profile_select_inputs = 4'hA;
      step();
      check(32'(amp_timer_reload), 32'h0000_0000);
   endtask : t_amp

   task automatic t_global();
      wr(`DDSCR_ADDR_GFUNC2, 32'h0000_8000);
      upd();
      check(32'({chan_ctl[0].sweep_autoclr_pulse, chan_ctl[1].sweep_autoclr_pulse,
                 chan_ctl[2].sweep_autoclr_pulse, chan_ctl[3].sweep_autoclr_pulse}),
            32'h0000_000F);
      wr(`DDSCR_ADDR_GFUNC2, 32'h0000_0000);
      upd();
      check(32'({chan_ctl[0].sweep_autoclr_pulse, chan_ctl[3].sweep_autoclr_pulse}),
            32'h0000_0000);
   endtask : t_global

   // ==========================================================================
   // main sequence and hang guard
   initial
   begin
      repeat (6) @(posedge core_clk);
      #2;
      sys_rst = 1'b0;
      t_reset();
      t_buffer();
      t_func();
      t_amp();
      t_global();
      stop_test();
   end

   initial
   begin
      repeat (2000) @(posedge core_clk);
      fails++;
      stop_test();
   end
endmodule : ddscr_regs_tb
`default_nettype wire
